//--- common/dcc_regs.svh
// register offsets, field positions and reset values of the comparator block
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_OFS_CTRL0    12'h000
`define DCC_OFS_CTRL1    12'h004
`define DCC_OFS_STATUS   12'h008
`define DCC_OFS_MASK     12'h00c
`define DCC_OFS_PORTCTL  12'h010
`define DCC_OFS_PORTDAT  12'h014
`define DCC_OFS_PORTRD   12'h018
`define DCC_OFS_SLEEP    12'h01c
`define DCC_BIT_SEL      7
`define DCC_BIT_ON       6
`define DCC_BIT_INV      5
`define DCC_BIT_RES      4
`define DCC_BIT_ROUTE    3
`define DCC_BIT_HYS      0
`define DCC_CTRL_RST     8'h81
`define DCC_CTRL_WMASK   8'he9
`endif

//--- common/dcc_pkg.sv
// types shared by the comparator control block
package dcc_pkg;
    typedef struct packed {
        logic sel;
        logic on;
        logic inv;
        logic route;
        logic hys;
    } dcc_ctrl_t;
    typedef struct packed {
        logic pin_select;
        logic powered;
        logic hysteresis;
        logic pullup_cut;
        logic out_drive;
    } dcc_analog_t;
endpackage

//--- src/dcc_chan.sv
// one comparator channel: sync, polarity, change detect, pin routing
`timescale 1ns/1ns
`default_nettype none
module dcc_chan
    import dcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire dcc_ctrl_t   ctrl,
    input  wire logic        raw_in,
    output var  logic        result,
    output var  logic        changed,
    output var  dcc_analog_t ana
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic res_reg;
    logic res_next;
    wire  agree = (s2_reg == s3_reg);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            res_reg <= 1'b0;
        end else begin
            s1_reg  <= raw_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            res_reg <= res_next;
        end
    end
    // polarity applied after sync; hold while filter disagrees
    assign res_next = !ctrl.on ? 1'b0 : (agree ? (s3_reg ^ ctrl.inv) : res_reg);
    assign result   = res_reg;
    assign changed  = res_reg != res_next;
    assign ana.pin_select = ctrl.sel;
    assign ana.powered    = ctrl.on;
    assign ana.hysteresis = ctrl.hys;
    assign ana.pullup_cut = ctrl.sel;
    assign ana.out_drive  = ctrl.sel & ~ctrl.route;
endmodule
`default_nettype wire

//--- src/dcc_top.sv
// dual comparator control with apb registers and interrupt logic
// Overview of operation
// - two control registers share one bit layout
// - pin-select high gives both input pins to the comparator
// - pin-select high disconnects pull-high resistors on shared pins
// - enable low powers the comparator off
// - polarity bit inverts the comparator result
// - result bit reads positive-above-negative, reversed when inverted
// - output pin driven only when route is zero and pin-select high
// - bits two and one ignore writes and read zero
// - hysteresis bit enables hysteresis
// - any output change sets that comparator's interrupt flag
// - change seen on the polarity-adjusted result bit, not the pin
// - new flag of an enabled comparator wakes from sleep or idle
// - no wake when the flag was already set
// - enabled comparator keeps running during sleep and idle
// - enabled comparator pins read zero or port data by control
`include "dcc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module dcc_top
    import dcc_pkg::*;
#(
    parameter int NPORT = 4
)(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    input  wire logic [1:0]       cmp_raw,
    input  wire logic [NPORT-1:0] port_pin_in,
    output var  dcc_analog_t      cmp_a_analog,
    output var  dcc_analog_t      cmp_b_analog,
    output var  logic             cmp_a_output_pin,
    output var  logic             cmp_b_output_pin,
    output var  logic             irq,
    output var  logic             wakeup
);
    generate
        if (NPORT < 2 || NPORT > 32) begin : g_bad_nport
            $error("NPORT out of range");
        end
    endgenerate
    logic [7:0]       ctrl_reg [2];
    logic [1:0]       flag_reg;
    logic [1:0]       mask_reg;
    logic [NPORT-1:0] pctl_reg;
    logic [NPORT-1:0] pdat_reg;
    logic             sleep_reg;
    logic [1:0]       pin_reg;
    logic [31:0]      prdata_reg;
    logic [1:0]       result;
    logic [1:0]       changed;
    dcc_analog_t      ana [2];
    dcc_ctrl_t        cfg [2];
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire hit_c0  = paddr == `DCC_OFS_CTRL0;
    wire hit_c1  = paddr == `DCC_OFS_CTRL1;
    wire hit_st  = paddr == `DCC_OFS_STATUS;
    wire hit_mk  = paddr == `DCC_OFS_MASK;
    wire hit_pc  = paddr == `DCC_OFS_PORTCTL;
    wire hit_pd  = paddr == `DCC_OFS_PORTDAT;
    wire hit_pr  = paddr == `DCC_OFS_PORTRD;
    wire hit_sl  = paddr == `DCC_OFS_SLEEP;
    wire hit_any = hit_c0 | hit_c1 | hit_st | hit_mk | hit_pc | hit_pd | hit_pr | hit_sl;
    wire [1:0] hit_c = {hit_c1, hit_c0};
    wire [1:0] sel_v = {cfg[1].sel, cfg[0].sel};
    wire [1:0] on_v  = {cfg[1].on, cfg[0].on};
    // comparator pins are port bits 0 and 1, one bit per channel, set while that channel is enabled
    logic [NPORT-1:0] cmp_pins;
    always_comb begin
        cmp_pins = '0;
        cmp_pins[1:0] = on_v;
    end
    wire [NPORT-1:0] port_read = (cmp_pins & ~pctl_reg & pdat_reg)
                               | (~cmp_pins & port_pin_in);
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            // identical layout for both channels
            assign cfg[i] = '{sel:   ctrl_reg[i][`DCC_BIT_SEL],
                              on:    ctrl_reg[i][`DCC_BIT_ON],
                              inv:   ctrl_reg[i][`DCC_BIT_INV],
                              route: ctrl_reg[i][`DCC_BIT_ROUTE],
                              hys:   ctrl_reg[i][`DCC_BIT_HYS]};
            dcc_chan u_chan (
                .clk     (clk),
                .nrst    (nrst),
                .ctrl    (cfg[i]),
                .raw_in  (cmp_raw[i]),
                .result  (result[i]),
                .changed (changed[i]),
                .ana     (ana[i])
            );
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ctrl_reg[i] <= `DCC_CTRL_RST;
                end else if (wr && hit_c[i]) begin
                    ctrl_reg[i] <= pwdata[7:0] & `DCC_CTRL_WMASK;
                end
            end
            // set wins over write-one-clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    flag_reg[i] <= 1'b0;
                end else if (changed[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (wr && hit_st && pwdata[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate
    // wake only on a fresh flag of an enabled comparator
    wire [1:0] wake_ev = changed & ~flag_reg & on_v;
    logic [7:0] ctrl_rd [2];
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            ctrl_rd[k] = ctrl_reg[k];
            ctrl_rd[k][`DCC_BIT_RES] = result[k];
        end
    end
    wire [31:0] rd_mux =
          hit_c0 ? {24'h000000, ctrl_rd[0]}
        : hit_c1 ? {24'h000000, ctrl_rd[1]}
        : hit_st ? {30'h00000000, flag_reg}
        : hit_mk ? {30'h00000000, mask_reg}
        : hit_pc ? 32'(pctl_reg)
        : hit_pd ? 32'(pdat_reg)
        : hit_pr ? 32'(port_read)
        : hit_sl ? {31'h00000000, sleep_reg}
        : 32'h00000000;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg   <= 2'h0;
            pctl_reg   <= '1;
            pdat_reg   <= '0;
            sleep_reg  <= 1'b0;
            prdata_reg <= 32'h00000000;
            pin_reg    <= 2'h0;
        end else begin
            if (wr && hit_mk) mask_reg <= pwdata[1:0];
            if (wr && hit_pc) pctl_reg <= pwdata[NPORT-1:0];
            if (wr && hit_pd) pdat_reg <= pwdata[NPORT-1:0];
            if (wr && hit_sl) sleep_reg <= pwdata[0];
            if (wake_ev != 2'h0) sleep_reg <= 1'b0;
            if (psel && !penable && !pwrite) prdata_reg <= rd_mux;
            pin_reg <= result & {ana[1].out_drive, ana[0].out_drive};
        end
    end
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;
    assign cmp_a_analog     = ana[0];
    assign cmp_b_analog     = ana[1];
    assign cmp_a_output_pin = pin_reg[0];
    assign cmp_b_output_pin = pin_reg[1];
    assign irq    = |(flag_reg & mask_reg);
    assign wakeup = sleep_reg & (wake_ev != 2'h0);

    chk_flag_on_change: assert property (@(posedge clk) disable iff (!nrst)
        changed[0] |=> flag_reg[0]) else $error("flag a not set on change");
    chk_flag_b_change: assert property (@(posedge clk) disable iff (!nrst)
        changed[1] |=> flag_reg[1]) else $error("flag b not set on change");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_reg[0][2:1] == 2'h0 && ctrl_reg[1][2:1] == 2'h0) else $error("reserved bits set");
    chk_pin_route: assert property (@(posedge clk) disable iff (!nrst)
        !ana[0].out_drive |=> !cmp_a_output_pin)
        else $error("pin driven while internal");
    chk_pullup_cut: assert property (@(posedge clk) disable iff (!nrst)
        cmp_a_analog.pullup_cut == cfg[0].sel) else $error("pullup not cut");
    chk_power_off: assert property (@(posedge clk) disable iff (!nrst)
        !cfg[1].on |-> !cmp_b_analog.powered) else $error("comparator powered while off");
    chk_no_rewake: assert property (@(posedge clk) disable iff (!nrst)
        (changed[0] && flag_reg[0] && !changed[1]) |-> !wakeup)
        else $error("wake with flag already set");
    chk_off_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !cfg[0].on ##1 !cfg[0].on |-> !changed[0]) else $error("change while off");
    chk_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        irq == |(flag_reg & mask_reg)) else $error("irq mismatch");
    chk_hys: assert property (@(posedge clk) disable iff (!nrst)
        cmp_b_analog.hysteresis == cfg[1].hys) else $error("hysteresis mismatch");
    cov_change_a: cover property (@(posedge clk) disable iff (!nrst) changed[0]);
    cov_wake: cover property (@(posedge clk) disable iff (!nrst) wakeup);
    cov_irq: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
endmodule
`default_nettype wire

//--- verif/dcc_ana_model.sv
// analog source model driving the raw comparator results
`timescale 1ns/1ns
`default_nettype none
module dcc_ana_model
    import dcc_pkg::*;
(
    input  wire logic        clk,
    input  wire dcc_analog_t ana_a,
    input  wire dcc_analog_t ana_b,
    input  wire logic [7:0]  vp_a,
    input  wire logic [7:0]  vn_a,
    input  wire logic [7:0]  vp_b,
    input  wire logic [7:0]  vn_b,
    output var  logic [1:0]  cmp_raw
);
    // powered-off comparator gives no result
    always_ff @(posedge clk) begin
        cmp_raw <= {ana_b.powered & (vp_b > vn_b), ana_a.powered & (vp_a > vn_a)};
    end
endmodule
`default_nettype wire

//--- verif/dual_comparator_control_tb.sv
// self-checking bench for the dual comparator control
`include "dcc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_control_tb
    import dcc_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  port_in = 4'hf;
    logic [7:0]  vp_a = 8'h10;
    logic [7:0]  vn_a = 8'h80;
    logic [7:0]  vp_b = 8'h10;
    logic [7:0]  vn_b = 8'h80;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [1:0]  cmp_raw;
    logic        pready, pslverr, irq, wakeup, pin_a, pin_b, err, seen;
    dcc_analog_t ana_a, ana_b;
    int          fails = 0;
    int          compares = 0;
    always #2 clk = ~clk;
    dcc_top #(.NPORT(4)) u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(cmp_raw), .port_pin_in(port_in), .cmp_a_analog(ana_a),
        .cmp_b_analog(ana_b), .cmp_a_output_pin(pin_a), .cmp_b_output_pin(pin_b),
        .irq(irq), .wakeup(wakeup));
    dcc_ana_model u_ana (.clk(clk), .ana_a(ana_a), .ana_b(ana_b), .vp_a(vp_a),
        .vn_a(vn_a), .vp_b(vp_b), .vn_b(vn_b), .cmp_raw(cmp_raw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            fails++;
            summarize();
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic poll();
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (wakeup === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic t_reset();
        rdchk(`DCC_OFS_CTRL0, 32'h81);
        rdchk(`DCC_OFS_CTRL1, 32'h81);
        rdchk(`DCC_OFS_STATUS, 32'h0);
        chk({27'h0, ana_a}, 32'h17);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_bits();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `DCC_OFS_CTRL0 + 12'(4 * i), 32'hff);
            tick(8);
            rdchk(`DCC_OFS_CTRL0 + 12'(4 * i), 32'hf9);
        end
        chk({27'h0, ana_a}, 32'h1e);
        chk({27'h0, ana_b}, 32'h1e);
        chk({31'h0, pin_b}, 32'h0);
        rdchk(`DCC_OFS_STATUS, 32'h3);
        apb(1'b1, `DCC_OFS_STATUS, 32'h3);
        rdchk(`DCC_OFS_STATUS, 32'h0);
    endtask
    task automatic t_result();
        apb(1'b1, `DCC_OFS_CTRL0, 32'hc0);
        tick(8);
        rdchk(`DCC_OFS_CTRL0, 32'hc0);
        vp_a <= 8'hc0;
        tick(8);
        rdchk(`DCC_OFS_CTRL0, 32'hd0);
        chk({31'h0, pin_a}, 32'h1);
        rdchk(`DCC_OFS_STATUS, 32'h1);
        apb(1'b1, `DCC_OFS_CTRL0, 32'hc8);
        tick(2);
        chk({31'h0, pin_a}, 32'h0);
        apb(1'b1, `DCC_OFS_STATUS, 32'h3);
    endtask
    task automatic t_irq();
        apb(1'b1, `DCC_OFS_MASK, 32'h1);
        vp_a <= 8'h10;
        tick(8);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `DCC_OFS_MASK, 32'h0);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `DCC_OFS_MASK, 32'h1);
        apb(1'b1, `DCC_OFS_STATUS, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_wake();
        apb(1'b1, `DCC_OFS_SLEEP, 32'h1);
        vp_a <= 8'hc0;
        poll();
        chk({31'h0, seen}, 32'h1);
        apb(1'b1, `DCC_OFS_SLEEP, 32'h1);
        vp_a <= 8'h10;
        poll();
        chk({31'h0, seen}, 32'h0);
        rdchk(`DCC_OFS_CTRL0, 32'hc8);
    endtask
    task automatic t_port();
        apb(1'b1, `DCC_OFS_PORTDAT, 32'h3);
        apb(1'b1, `DCC_OFS_PORTCTL, 32'h0);
        apb(1'b0, `DCC_OFS_PORTRD, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, `DCC_OFS_PORTCTL, 32'h1);
        apb(1'b0, `DCC_OFS_PORTRD, 32'h0);
        chk(rd & 32'h1, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_bits();
        t_result();
        t_irq();
        t_wake();
        t_port();
        summarize();
    end
endmodule
`default_nettype wire
